//--- tcd_dma_top.v
// Two-channel memory to memory copy engine with Avalon-MM register slave
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`include "tcd_defines.vh"

// Behaviour
// R1: Start on selected factor or software trigger
// R2: Mode bit zero steal, one burst
// R3: Steal mode moves one byte per request
// R4: Burst moves whole count per request
// R5: Index bit picks channel for shared registers
// R6: Write control picks latch only or both
// R7: Software reads high first, writes low first
// R8: Writing trigger bit one raises request
// R9: Addresses step up, down, or hold
// R10: Underflow reloads addresses unless reload disabled
// R11: Underflow always reloads count from latch
// R12: Underflow sets interrupt and underflow flags
// R13: Underflow clears enable when option set
// R14: Reload bit copies latches into registers
// R15: Software may mask factor's CPU interrupt; this engine has no such mask
// R16: Sixteen mode bits per channel, two registers
// R17: Channel 0 wins; burst yields between bytes
// R18: Interrupt suspends, sets flag, resumes after
// R19: Enable write resumes suspended transfer
// R20: Disabled channel ignores all requests
module tcd_dma_top #(
    parameter NUM_FACTORS = 16,
    parameter SEL_W = 4
) (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire i_ce,
    input wire [5:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    output reg [15:0] o_mem_address,
    output reg o_mem_read,
    output reg o_mem_write,
    output reg [7:0] o_mem_writedata,
    input wire [7:0] i_mem_readdata,
    input wire i_mem_waitrequest,
    input wire [NUM_FACTORS-1:0] i_req_factor,
    input wire i_cpu_irq_active,
    output reg [1:0] o_dma_irq,
    output reg o_busy
);

    localparam ST_IDLE = 2'h0;
    localparam ST_READ = 2'h1;
    localparam ST_WRITE = 2'h2;
    localparam ST_STEP = 2'h3;

    // ==========================================
    // Channel storage
    reg [15:0] src [0:1];
    reg [15:0] dst [0:1];
    reg [15:0] cnt [0:1];
    reg [15:0] src_latch [0:1];
    reg [15:0] dst_latch [0:1];
    reg [15:0] cnt_latch [0:1];
    reg [6:0] mode_lo [0:1];
    reg [SEL_W-1:0] hw_request_source_sel [0:1];
    reg [1:0] channel_enable_bit;
    reg chan_sel;
    reg reload_dis;
    reg [1:0] uflow;
    reg [1:0] suspend_flag;
    reg [1:0] resume_ovr;
    reg [1:0] pend;
    reg [1:0] burst;
    reg [1:0] soft_trig;
    reg [7:0] wr_temp;
    reg [7:0] rd_temp;
    reg irq_prev;
    reg [1:0] state;
    reg cur;

    wire [1:0] req_ev;
    wire [1:0] elig;
    wire bus_wr;
    wire bus_rd;
    wire irq_fall;
    integer c;

    function [15:0] step_addr;
        input [15:0] a;
        input [1:0] m;
        begin
            case (m)
                `TCD_STEP_INC: step_addr = a + 16'h0001;
                `TCD_STEP_DEC: step_addr = a - 16'h0001;
                default: step_addr = a;
            endcase
        end
    endfunction

    // ==========================================
    // Request detectors
    tcd_req_detect #(
        .NUM_FACTORS(NUM_FACTORS),
        .SEL_W(SEL_W)
    ) u_req0 (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_factor(i_req_factor),
        .i_sel(hw_request_source_sel[0]),
        .i_enable(channel_enable_bit[0]),
        .i_soft_trig(soft_trig[0]),
        .o_req(req_ev[0])
    );

    tcd_req_detect #(
        .NUM_FACTORS(NUM_FACTORS),
        .SEL_W(SEL_W)
    ) u_req1 (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_factor(i_req_factor),
        .i_sel(hw_request_source_sel[1]),
        .i_enable(channel_enable_bit[1]),
        .i_soft_trig(soft_trig[1]),
        .o_req(req_ev[1])
    );

    // A channel may run only when enabled and not held by a CPU interrupt
    assign elig[0] = channel_enable_bit[0] & (pend[0] | burst[0])
        & (~i_cpu_irq_active | resume_ovr[0]); // R18 R19 R20
    assign elig[1] = channel_enable_bit[1] & (pend[1] | burst[1])
        & (~i_cpu_irq_active | resume_ovr[1]); // R18 R19 R20
    assign bus_wr = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
    assign bus_rd = i_avs_read & ~o_avs_waitrequest;
    assign irq_fall = irq_prev & ~i_cpu_irq_active;

    // ==========================================
    // Bus slave handshake and read data
    // One wait cycle per access; read data is built while waitrequest is high
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h00000000;
        end else if (i_ce) begin
            if ((i_avs_read | i_avs_write) & o_avs_waitrequest) begin
                o_avs_waitrequest <= 1'b0;
                o_avs_readdata <= 32'h00000000;
                case (i_avs_address)
                    `TCD_REG_INDEX: begin
                        o_avs_readdata[7:0] <= {suspend_flag, o_dma_irq, uflow,
                            reload_dis, chan_sel};
                    end
                    `TCD_REG_MODE_LO: begin
                        o_avs_readdata[7:0] <= {1'b0, mode_lo[chan_sel]}; // R5 R16
                    end
                    `TCD_REG_MODE_HI: begin
                        o_avs_readdata[7:0] <= {2'h0, channel_enable_bit[chan_sel], 1'b0,
                            hw_request_source_sel[chan_sel]}; // R5 R16
                    end
                    `TCD_REG_SRC_HI: o_avs_readdata[7:0] <= src[chan_sel][15:8]; // R7
                    `TCD_REG_DST_HI: o_avs_readdata[7:0] <= dst[chan_sel][15:8]; // R7
                    `TCD_REG_CNT_HI: o_avs_readdata[7:0] <= cnt[chan_sel][15:8]; // R7
                    `TCD_REG_SRC_LO: o_avs_readdata[7:0] <= rd_temp; // R7
                    `TCD_REG_DST_LO: o_avs_readdata[7:0] <= rd_temp; // R7
                    `TCD_REG_CNT_LO: o_avs_readdata[7:0] <= rd_temp; // R7
                    default: o_avs_readdata <= 32'h00000000;
                endcase
            end else begin
                o_avs_waitrequest <= 1'b1;
            end
        end
    end

    // ==========================================
    // Registers, flags and copy engine
    // Engine updates come after bus writes, so hardware events win same-cycle clears
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            for (c = 0; c < 2; c = c + 1) begin
                src[c] <= `TCD_RST_WORD;
                dst[c] <= `TCD_RST_WORD;
                cnt[c] <= `TCD_RST_WORD;
                src_latch[c] <= `TCD_RST_WORD;
                dst_latch[c] <= `TCD_RST_WORD;
                cnt_latch[c] <= `TCD_RST_WORD;
                mode_lo[c] <= 7'h00;
                hw_request_source_sel[c] <= {SEL_W{1'b0}};
            end
            channel_enable_bit <= 2'h0;
            chan_sel <= 1'b0;
            reload_dis <= 1'b0;
            uflow <= 2'h0;
            o_dma_irq <= 2'h0;
            suspend_flag <= 2'h0;
            resume_ovr <= 2'h0;
            pend <= 2'h0;
            burst <= 2'h0;
            soft_trig <= 2'h0;
            wr_temp <= `TCD_RST_BYTE;
            rd_temp <= `TCD_RST_BYTE;
            irq_prev <= 1'b0;
            state <= ST_IDLE;
            cur <= 1'b0;
            o_mem_address <= `TCD_RST_WORD;
            o_mem_read <= 1'b0;
            o_mem_write <= 1'b0;
            o_mem_writedata <= `TCD_RST_BYTE;
            o_busy <= 1'b0;
        end else if (i_ce) begin
            soft_trig <= 2'h0;
            irq_prev <= i_cpu_irq_active;

            // Register reads with side effects
            if (bus_rd) begin
                case (i_avs_address)
                    `TCD_REG_SRC_HI: rd_temp <= src[chan_sel][7:0]; // R7
                    `TCD_REG_DST_HI: rd_temp <= dst[chan_sel][7:0]; // R7
                    `TCD_REG_CNT_HI: rd_temp <= cnt[chan_sel][7:0]; // R7
                    default: rd_temp <= rd_temp;
                endcase
            end

            // Register writes; the high byte write commits the word
            if (bus_wr) begin
                case (i_avs_address)
                    `TCD_REG_INDEX: begin
                        chan_sel <= i_avs_writedata[`TCD_IX_CHAN_SEL]; // R5
                        reload_dis <= i_avs_writedata[`TCD_IX_RELOAD_DIS];
                        uflow <= uflow & ~i_avs_writedata[`TCD_IX_UFLOW1:`TCD_IX_UFLOW0];
                        o_dma_irq <= o_dma_irq & ~i_avs_writedata[`TCD_IX_IRQ1:`TCD_IX_IRQ0];
                    end
                    `TCD_REG_MODE_LO: begin
                        mode_lo[chan_sel] <= i_avs_writedata[6:0]; // R2 R9 R16
                        soft_trig[chan_sel] <= i_avs_writedata[`TCD_ML_SOFT_TRIG]; // R8
                    end
                    `TCD_REG_MODE_HI: begin
                        hw_request_source_sel[chan_sel] <=
                            i_avs_writedata[`TCD_MH_SRC_SEL_LSB +: SEL_W]; // R1 R16
                        channel_enable_bit[chan_sel] <= i_avs_writedata[`TCD_MH_ENABLE];
                        if (i_avs_writedata[`TCD_MH_ENABLE] & suspend_flag[chan_sel]) begin
                            resume_ovr[chan_sel] <= 1'b1; // R19
                        end
                        if (i_avs_writedata[`TCD_MH_RELOAD]) begin
                            src[chan_sel] <= src_latch[chan_sel]; // R14
                            dst[chan_sel] <= dst_latch[chan_sel]; // R14
                            cnt[chan_sel] <= cnt_latch[chan_sel]; // R14
                        end
                    end
                    `TCD_REG_SRC_LO: wr_temp <= i_avs_writedata[7:0]; // R7
                    `TCD_REG_DST_LO: wr_temp <= i_avs_writedata[7:0]; // R7
                    `TCD_REG_CNT_LO: wr_temp <= i_avs_writedata[7:0]; // R7
                    `TCD_REG_SRC_HI: begin
                        src_latch[chan_sel] <= {i_avs_writedata[7:0], wr_temp};
                        if (!mode_lo[chan_sel][`TCD_ML_LATCH_ONLY]) begin
                            src[chan_sel] <= {i_avs_writedata[7:0], wr_temp}; // R6
                        end
                    end
                    `TCD_REG_DST_HI: begin
                        dst_latch[chan_sel] <= {i_avs_writedata[7:0], wr_temp};
                        if (!mode_lo[chan_sel][`TCD_ML_LATCH_ONLY]) begin
                            dst[chan_sel] <= {i_avs_writedata[7:0], wr_temp}; // R6
                        end
                    end
                    `TCD_REG_CNT_HI: begin
                        cnt_latch[chan_sel] <= {i_avs_writedata[7:0], wr_temp};
                        if (!mode_lo[chan_sel][`TCD_ML_LATCH_ONLY]) begin
                            cnt[chan_sel] <= {i_avs_writedata[7:0], wr_temp}; // R6
                        end
                    end
                    default: wr_temp <= wr_temp;
                endcase
            end

            // Suspension follows the CPU interrupt level
            for (c = 0; c < 2; c = c + 1) begin
                if (irq_fall) begin
                    suspend_flag[c] <= 1'b0; // R18
                    resume_ovr[c] <= 1'b0;
                end else if (i_cpu_irq_active & channel_enable_bit[c]
                    & (pend[c] | burst[c]) & ~resume_ovr[c]) begin
                    suspend_flag[c] <= 1'b1; // R18
                end
            end

            // Request capture; a new request beats the acceptance clear
            for (c = 0; c < 2; c = c + 1) begin
                if (req_ev[c]) begin
                    pend[c] <= 1'b1; // R1
                end
            end

            case (state)
                ST_IDLE: begin
                    // Returning here after every byte lets channel 0 cut into a burst
                    if (elig[0] | elig[1]) begin
                        cur <= ~elig[0]; // R17
                        state <= ST_READ;
                        o_busy <= 1'b1;
                        o_mem_read <= 1'b1;
                        o_mem_address <= elig[0] ? src[0] : src[1]; // R3
                        if (elig[0]) begin
                            pend[0] <= req_ev[0];
                            burst[0] <= mode_lo[0][`TCD_ML_BURST]; // R2 R4
                        end else begin
                            pend[1] <= req_ev[1];
                            burst[1] <= mode_lo[1][`TCD_ML_BURST]; // R2 R4
                        end
                    end else begin
                        o_busy <= 1'b0;
                    end
                end
                ST_READ: begin
                    if (!i_mem_waitrequest) begin
                        o_mem_read <= 1'b0;
                        o_mem_write <= 1'b1;
                        o_mem_address <= dst[cur]; // R3
                        o_mem_writedata <= i_mem_readdata;
                        state <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (!i_mem_waitrequest) begin
                        o_mem_write <= 1'b0;
                        state <= ST_STEP;
                    end
                end
                ST_STEP: begin
                    state <= ST_IDLE;
                    if (cnt[cur] == 16'h0000) begin
                        cnt[cur] <= cnt_latch[cur]; // R11
                        burst[cur] <= 1'b0; // R4
                        uflow[cur] <= 1'b1; // R12
                        o_dma_irq[cur] <= 1'b1; // R12
                        if (mode_lo[cur][`TCD_ML_DIS_UFLOW]) begin
                            channel_enable_bit[cur] <= 1'b0; // R13
                        end
                        if (!reload_dis) begin
                            src[cur] <= src_latch[cur]; // R10
                            dst[cur] <= dst_latch[cur]; // R10
                        end else begin
                            src[cur] <= step_addr(src[cur],
                                mode_lo[cur][`TCD_ML_SRC_STEP_LSB +: 2]); // R9
                            dst[cur] <= step_addr(dst[cur],
                                mode_lo[cur][`TCD_ML_DST_STEP_LSB +: 2]); // R9
                        end
                    end else begin
                        cnt[cur] <= cnt[cur] - 16'h0001; // R4
                        src[cur] <= step_addr(src[cur],
                            mode_lo[cur][`TCD_ML_SRC_STEP_LSB +: 2]); // R9
                        dst[cur] <= step_addr(dst[cur],
                            mode_lo[cur][`TCD_ML_DST_STEP_LSB +: 2]); // R9
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule

//--- tcd_defines.vh
// Register map, field positions and reset values of the two-channel memory copy engine
`ifndef TCD_DEFINES_VH
`define TCD_DEFINES_VH

// ==========================================
// Register byte offsets
`define TCD_REG_INDEX    6'h00
`define TCD_REG_MODE_LO  6'h04
`define TCD_REG_MODE_HI  6'h08
`define TCD_REG_SRC_LO   6'h0c
`define TCD_REG_SRC_HI   6'h10
`define TCD_REG_DST_LO   6'h14
`define TCD_REG_DST_HI   6'h18
`define TCD_REG_CNT_LO   6'h1c
`define TCD_REG_CNT_HI   6'h20

// ==========================================
// Index and status register fields
`define TCD_IX_CHAN_SEL    0
`define TCD_IX_RELOAD_DIS  1
`define TCD_IX_UFLOW0      2
`define TCD_IX_UFLOW1      3
`define TCD_IX_IRQ0        4
`define TCD_IX_IRQ1        5
`define TCD_IX_SUSP0       6
`define TCD_IX_SUSP1       7

// ==========================================
// Mode register low fields
`define TCD_ML_SRC_STEP_LSB  0
`define TCD_ML_DST_STEP_LSB  2
`define TCD_ML_BURST         4
`define TCD_ML_LATCH_ONLY    5
`define TCD_ML_DIS_UFLOW     6
`define TCD_ML_SOFT_TRIG     7

// ==========================================
// Mode register high fields
`define TCD_MH_SRC_SEL_LSB   0
`define TCD_MH_RELOAD        4
`define TCD_MH_ENABLE        5

// ==========================================
// Address step encodings
`define TCD_STEP_INC  2'h1
`define TCD_STEP_DEC  2'h2

// ==========================================
// Reset values
`define TCD_RST_BYTE  8'h00
`define TCD_RST_WORD  16'h0000

`endif

//--- tcd_req_detect.v
// Request detector for one channel: selected factor edge or software trigger
`timescale 1ns/10ps

module tcd_req_detect #(
    parameter NUM_FACTORS = 16,
    parameter SEL_W = 4
) (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire i_ce,
    input wire [NUM_FACTORS-1:0] i_factor,
    input wire [SEL_W-1:0] i_sel,
    input wire i_enable,
    input wire i_soft_trig,
    output reg o_req
);

    wire sel_level;
    reg sel_prev;

    assign sel_level = i_factor[i_sel];

    // ==========================================
    // Edge of the chosen factor, so a level held high counts once
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            sel_prev <= 1'b0;
            o_req <= 1'b0;
        end else if (i_ce) begin
            sel_prev <= sel_level;
            o_req <= i_enable & ((sel_level & ~sel_prev) | i_soft_trig); // R1 R8 R20
        end
    end

endmodule

//--- tcd_mem_model.sv
// Byte memory model on the far side of the copy engine master port
`timescale 1ns/10ps
module tcd_mem_model (
    input wire i_clk_sys,
    input wire i_stall,
    input wire [15:0] i_addr,
    input wire i_read,
    output wire o_wait,
    output wire [7:0] o_rdata
);
    reg [7:0] churn = 8'h00;
    // ==========================================
    // Read data
    // Outside a read the lines move every cycle, so stale data cannot pass
    always @(posedge i_clk_sys) churn <= churn + 8'h3b;
    assign o_wait = i_stall;
    assign o_rdata = i_read ? (i_addr[7:0] ^ 8'h5a) : ~churn;
endmodule

//--- tcd_dma_top_chk.sv
// Port checker for the two-channel memory copy engine
`timescale 1ns/10ps
module tcd_dma_top_chk (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire [5:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] o_avs_readdata,
    input wire o_avs_waitrequest,
    input wire [15:0] o_mem_address,
    input wire o_mem_read,
    input wire o_mem_write,
    input wire [7:0] o_mem_writedata,
    input wire i_mem_waitrequest,
    input wire [1:0] o_dma_irq,
    input wire o_busy
);
    // ==========================================
    // Clocking
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);
    // ==========================================
    // Assertions
    a_bus_answer: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("register bus answer late");
    a_answer_once: assert property (
        !o_avs_waitrequest |=> o_avs_waitrequest) else $error("answer stands too long");
    a_read_upper: assert property (
        !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0) else $error("readdata upper set");
    a_read_then_write: assert property (
        o_mem_read && !i_mem_waitrequest |=> o_mem_write) else $error("no write after read");
    a_byte_gap: assert property (
        o_mem_write && !i_mem_waitrequest |=> (!o_mem_read && !o_mem_write) [*2])
        else $error("step and idle cycles missing");
    a_read_hold: assert property (
        o_mem_read && i_mem_waitrequest |=> o_mem_read && $stable(o_mem_address))
        else $error("memory read dropped");
    a_write_hold: assert property (
        o_mem_write && i_mem_waitrequest |=> o_mem_write && $stable({o_mem_address,
        o_mem_writedata})) else $error("memory write dropped");
    a_busy_moving: assert property (
        o_mem_read || o_mem_write |-> o_busy) else $error("busy low while moving");
    a_irq_cause: assert property (
        $rose(o_dma_irq[0]) || $rose(o_dma_irq[1]) |->
        $past(o_mem_write, 2) && !$past(i_mem_waitrequest, 2)) else $error("irq without byte");
    a_irq_sticky: assert property (
        o_dma_irq[0] && !(i_avs_write && !o_avs_waitrequest && i_avs_address == 6'h00)
        |=> o_dma_irq[0]) else $error("irq dropped by itself");
endmodule

bind tcd_dma_top tcd_dma_top_chk u_chk (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_mem_address(o_mem_address),
    .o_mem_read(o_mem_read),
    .o_mem_write(o_mem_write),
    .o_mem_writedata(o_mem_writedata),
    .i_mem_waitrequest(i_mem_waitrequest),
    .o_dma_irq(o_dma_irq),
    .o_busy(o_busy)
);

//--- tcd_dma_top_test.sv
// Self-checking bench for the two-channel memory copy engine
`timescale 1ns/10ps
`include "tcd_defines.vh"
module tcd_dma_top_test;
    reg i_clk_sys = 1'b0;
    reg i_rstn = 1'b0;
    reg [5:0] bus_addr = 6'h00;
    reg bus_rd = 1'b0;
    reg bus_wr = 1'b0;
    reg [31:0] bus_wdata = 32'h0;
    reg [15:0] factor = 16'h0000;
    reg cpu_irq = 1'b0;
    reg stall = 1'b0;
    wire [31:0] bus_rdata;
    wire bus_wait;
    wire [15:0] mem_addr;
    wire mem_rd;
    wire mem_wr;
    wire [7:0] mem_wdata;
    wire [7:0] mem_rdata;
    wire mem_wait;
    wire [1:0] irq;
    wire busy;
    integer miscompares = 0;
    integer n_tests = 0;
    integer cycles = 0;
    integer seed = 32'h98f6;
    logic [31:0] rq[$];
    logic [31:0] mq[$];

    tcd_dma_top u_dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(1'b1),
        .i_avs_address(bus_addr), .i_avs_read(bus_rd), .i_avs_write(bus_wr),
        .i_avs_writedata(bus_wdata), .i_avs_byteenable(4'h1), .o_avs_readdata(bus_rdata),
        .o_avs_waitrequest(bus_wait), .o_mem_address(mem_addr), .o_mem_read(mem_rd),
        .o_mem_write(mem_wr), .o_mem_writedata(mem_wdata), .i_mem_readdata(mem_rdata),
        .i_mem_waitrequest(mem_wait), .i_req_factor(factor), .i_cpu_irq_active(cpu_irq),
        .o_dma_irq(irq), .o_busy(busy));
    tcd_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_stall(stall), .i_addr(mem_addr),
        .i_read(mem_rd), .o_wait(mem_wait), .o_rdata(mem_rdata));

    always #25 i_clk_sys = ~i_clk_sys;

    // ==========================================
    // Checking and closing
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task results;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Random stalls on the memory side, about one cycle in four, keep some requests held for a while
    always @(posedge i_clk_sys) begin
        stall <= ($random(seed) & 3) == 0;
        cycles = cycles + 1;
        if (cycles == 12000) begin
            miscompares = miscompares + 1;
            results;
        end
    end
    always @(posedge i_clk_sys) begin
        if (bus_rd && bus_wait === 1'b0) chk("readdata", bus_rdata, rq.pop_front());
        if (mem_wr && mem_wait === 1'b0) begin
            if (mq.size() == 0) chk("stray write", 32'h1, 32'h0);
            else chk("mem write", {8'h0, mem_addr, mem_wdata}, mq.pop_front());
        end
    end

    // ==========================================
    // Drivers
    task bus(input [5:0] a, input w, input [7:0] d);
        @(posedge i_clk_sys);
        bus_addr <= a;
        bus_wr <= w;
        bus_rd <= !w;
        bus_wdata <= {24'h0, d};
        do @(posedge i_clk_sys); while (bus_wait !== 1'b0);
        bus_rd <= 1'b0;
        bus_wr <= 1'b0;
    endtask
    task rd(input [5:0] a, input [7:0] e);
        rq.push_back({24'h0, e});
        bus(a, 1'b0, 8'h00);
    endtask
    // Low byte first on write, high byte first on read
    task wr16(input [5:0] a, input [15:0] v);
        bus(a, 1'b1, v[7:0]);
        bus(a + 6'h4, 1'b1, v[15:8]);
    endtask
    task rd16(input [5:0] a, input [15:0] e);
        rd(a + 6'h4, e[15:8]);
        rd(a, e[7:0]);
    endtask
    task mv(input [15:0] dst, input [15:0] src);
        mq.push_back({8'h0, dst, src[7:0] ^ 8'h5a});
    endtask
    task drain;
        while (mq.size() != 0) @(posedge i_clk_sys);
        repeat (4) @(posedge i_clk_sys);
    endtask
    task pulse;
        factor[3] <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        factor[3] <= 1'b0;
    endtask

    // ==========================================
    // Scenarios
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        wr16(`TCD_REG_SRC_LO, 16'h0010);
        wr16(`TCD_REG_DST_LO, 16'h0100);
        wr16(`TCD_REG_CNT_LO, 16'h0002);
        bus(`TCD_REG_MODE_HI, 1'b1, 8'h20);
        mv(16'h0100, 16'h0010);
        bus(`TCD_REG_MODE_LO, 1'b1, 8'h85);
        drain;
        mv(16'h0101, 16'h0011);
        bus(`TCD_REG_MODE_LO, 1'b1, 8'h85);
        drain;
        rd16(`TCD_REG_SRC_LO, 16'h0012);
        rd16(`TCD_REG_DST_LO, 16'h0102);
        rd16(`TCD_REG_CNT_LO, 16'h0000);
        // Channel 1: latch only, manual reload, decrementing burst
        bus(`TCD_REG_INDEX, 1'b1, 8'h01);
        bus(`TCD_REG_MODE_LO, 1'b1, 8'h20);
        wr16(`TCD_REG_SRC_LO, 16'h0040);
        wr16(`TCD_REG_DST_LO, 16'h0200);
        wr16(`TCD_REG_CNT_LO, 16'h0001);
        rd16(`TCD_REG_SRC_LO, 16'h0000);
        bus(`TCD_REG_MODE_HI, 1'b1, 8'h30);
        rd16(`TCD_REG_SRC_LO, 16'h0040);
        mv(16'h0200, 16'h0040);
        mv(16'h01ff, 16'h003f);
        bus(`TCD_REG_MODE_LO, 1'b1, 8'hda);
        drain;
        rd(`TCD_REG_INDEX, 8'h29);
        rd(`TCD_REG_MODE_HI, 8'h00);
        rd16(`TCD_REG_SRC_LO, 16'h0040);
        rd16(`TCD_REG_CNT_LO, 16'h0001);
        rd(6'h3c, 8'h00);
        bus(`TCD_REG_INDEX, 1'b1, 8'h21);
        @(posedge i_clk_sys);
        chk("irq cleared", {30'h0, irq}, 32'h0);
        // Trigger on a disabled channel must move nothing
        bus(`TCD_REG_MODE_LO, 1'b1, 8'hda);
        repeat (40) @(posedge i_clk_sys);
        chk("idle", {31'h0, busy}, 32'h0);
        // Channel 0 from factor 3; third byte underflows
        bus(`TCD_REG_INDEX, 1'b1, 8'h00);
        bus(`TCD_REG_MODE_HI, 1'b1, 8'h23);
        mv(16'h0102, 16'h0012);
        pulse;
        drain;
        chk("irq ch0", {30'h0, irq}, 32'h1);
        // Both channels wait out a CPU interrupt; an enable write lets channel 0 go early
        cpu_irq <= 1'b1;
        bus(`TCD_REG_INDEX, 1'b1, 8'h01);
        bus(`TCD_REG_MODE_HI, 1'b1, 8'h20);
        bus(`TCD_REG_MODE_LO, 1'b1, 8'hda);
        bus(`TCD_REG_INDEX, 1'b1, 8'h00);
        pulse;
        repeat (10) @(posedge i_clk_sys);
        rd(`TCD_REG_INDEX, 8'hdc);
        mv(16'h0100, 16'h0010);
        mv(16'h0200, 16'h0040);
        mv(16'h01ff, 16'h003f);
        bus(`TCD_REG_MODE_HI, 1'b1, 8'h23);
        while (mq.size() != 2) @(posedge i_clk_sys);
        repeat (20) @(posedge i_clk_sys);
        chk("ch1 held", mq.size(), 32'h2);
        cpu_irq <= 1'b0;
        drain;
        chk("irq both", {30'h0, irq}, 32'h3);
        results;
    end
endmodule
